// >>> logic/oag_core.sv
// Operand and branch address generator of the microcontroller core.
// Assumes the decoder presents one request per cycle with all bytes fetched.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Register mode selects register by opcode low bits
// - Direct byte below 80h RAM, else SPECIAL_FUNCTION_REGISTER_SPACE
// - Indirect via R0/R1, high half upper RAM
// - Immediate byte stored at selected location
// - Sixteen-bit immediate loads the data pointer
// - External direct uses data pointer, read/write accumulator
// - External indirect mode refused, no access made
// - Code read address is accumulator plus base
// - Fetched code byte replaces the accumulator
// - Relative target adds signed offset to PC
// - Page target keeps five PC high bits
// - Long target is the two following bytes
// - Bit update leaves other seven bits alone
// - Bit access only 20h-2Fh and aligned SFRs
module oag_core #(
  parameter int unsigned ADDR_W = 16 // Program and data address width
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic req_valid, // Decoder request strobe
  input wire oag_pkg::oag_req_s req, // Decoder request
  input wire logic code_rvalid, // Code memory read data strobe
  input wire logic [7:0] code_rdata, // Code memory read data
  output var oag_pkg::oag_res_s res, // Generated address, one cycle later
  output logic code_pending, // Code table read outstanding
  output logic acc_load, // Accumulator write strobe
  output logic [7:0] acc_val // Value for the accumulator
);

  // Width the logic is built for
  if (ADDR_W != oag_pkg::ADDR_W) begin : g_width_check
    $error("oag_core supports only a 16-bit address width");
  end

  // All state of the block
  typedef struct packed {
    oag_pkg::oag_res_s res;
    logic pending;
    logic acc_load;
    logic [7:0] acc_val;
  } oag_state_s;

  oag_state_s st_ff;
  oag_state_s nxt_st;

  oag_pkg::oag_space_e bit_space;
  logic [7:0] bit_byte;
  logic [7:0] bit_mask;
  logic [7:0] bit_new;
  logic [7:0] ptr;

  // Base plus unsigned accumulator index
  function automatic logic [15:0] oag_index(input logic [15:0] base, input logic [7:0] idx);
    oag_index = base + {8'h00, idx};
  endfunction : oag_index

  // Program counter plus signed offset
  function automatic logic [15:0] oag_rel(input logic [15:0] pc, input logic [7:0] off);
    oag_rel = pc + {{8{off[7]}}, off};
  endfunction : oag_rel

  // Bit address decoding and masked update
  oag_bit_map i_oag_bit_map (
    .bit_addr(req.byte2),
    .cur_byte(req.cur_byte),
    .bit_val(req.bit_val),
    .space(bit_space),
    .byte_addr(bit_byte),
    .mask(bit_mask),
    .new_byte(bit_new)
  );

  // Pointer register selected by opcode bit 0
  assign ptr = req.opcode[0] ? req.ptr1 : req.ptr0;

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.res.valid = 1'b0;
    nxt_st.acc_load = 1'b0;
    // Code byte returns to the accumulator
    if (st_ff.pending && code_rvalid) begin
      nxt_st.pending = 1'b0;
      nxt_st.acc_load = 1'b1;
      nxt_st.acc_val = code_rdata;
    end
    if (req_valid) begin
      nxt_st.res = '0;
      nxt_st.res.valid = 1'b1;
      case (req.mode)
        oag_pkg::MODE_REG: begin
          nxt_st.res.space = oag_pkg::SPACE_REG;
          nxt_st.res.addr = {13'h0000,
            req.opcode[oag_pkg::REG_SEL_LSB +: oag_pkg::REG_SEL_W]};
        end
        oag_pkg::MODE_DIRECT: begin
          nxt_st.res.addr = {8'h00, req.byte2};
          if (req.byte2 < oag_pkg::UPPER_BASE) begin
            nxt_st.res.space = oag_pkg::SPACE_DATA;
          end else begin
            nxt_st.res.space = oag_pkg::SPACE_SFR;
          end
        end
        oag_pkg::MODE_INDIRECT: begin
          nxt_st.res.addr = {8'h00, ptr};
          if (ptr < oag_pkg::UPPER_BASE) begin
            nxt_st.res.space = oag_pkg::SPACE_DATA;
          end else begin
            nxt_st.res.space = oag_pkg::SPACE_UPPER;
          end
        end
        oag_pkg::MODE_IMM8: begin
          // Destination address rides in the opcode's register field
          nxt_st.res.space = oag_pkg::SPACE_REG;
          nxt_st.res.addr = {13'h0000,
            req.opcode[oag_pkg::REG_SEL_LSB +: oag_pkg::REG_SEL_W]};
          nxt_st.res.wdata = req.byte2;
          nxt_st.res.wr = 1'b1;
        end
        oag_pkg::MODE_IMM16: begin
          nxt_st.res.data_pointer_16_load = 1'b1;
          nxt_st.res.data_pointer_16_val = {req.byte2, req.byte3};
        end
        oag_pkg::MODE_EXT_DIRECT: begin
          nxt_st.res.space = oag_pkg::SPACE_EXT;
          nxt_st.res.addr = req.data_pointer_16;
          nxt_st.res.wr = req.ext_write;
          nxt_st.res.wdata = req.acc;
        end
        oag_pkg::MODE_EXT_INDIRECT: begin
          // No upper address byte exists, so nothing is accessed
          nxt_st.res.illegal = 1'b1;
        end
        oag_pkg::MODE_INDEXED_PC: begin
          nxt_st.res.space = oag_pkg::SPACE_CODE;
          nxt_st.res.addr = oag_index(req.pc_next, req.acc);
          nxt_st.pending = 1'b1;
        end
        oag_pkg::MODE_INDEXED_DATA_POINTER_16: begin
          nxt_st.res.space = oag_pkg::SPACE_CODE;
          nxt_st.res.addr = oag_index(req.data_pointer_16, req.acc);
          nxt_st.pending = 1'b1;
        end
        oag_pkg::MODE_RELATIVE: begin
          nxt_st.res.space = oag_pkg::SPACE_PC;
          nxt_st.res.branch = 1'b1;
          nxt_st.res.addr = oag_rel(req.pc_next, req.byte2);
        end
        oag_pkg::MODE_PAGE: begin
          nxt_st.res.space = oag_pkg::SPACE_PC;
          nxt_st.res.branch = 1'b1;
          nxt_st.res.addr = {req.pc_next[15:oag_pkg::PAGE_LOW_W],
            req.opcode[oag_pkg::PAGE_OPC_MSB:oag_pkg::PAGE_OPC_LSB], req.byte2};
        end
        oag_pkg::MODE_LONG: begin
          nxt_st.res.space = oag_pkg::SPACE_PC;
          nxt_st.res.branch = 1'b1;
          nxt_st.res.addr = {req.byte2, req.byte3};
        end
        oag_pkg::MODE_BIT: begin
          nxt_st.res.space = bit_space;
          nxt_st.res.addr = {8'h00, bit_byte};
          nxt_st.res.wdata = bit_new;
          nxt_st.res.wr = 1'b1;
        end
        default: begin
          nxt_st.res.illegal = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign res = st_ff.res;
  assign code_pending = st_ff.pending;
  assign acc_load = st_ff.acc_load;
  assign acc_val = st_ff.acc_val;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Request of a given mode
  sequence s_req(oag_pkg::oag_mode_e m);
    req_valid && req.mode == m;
  endsequence

  // Result of a given space one cycle on
  sequence s_res(oag_pkg::oag_space_e sp);
    ##1 res.valid && res.space == sp;
  endsequence

  property p_reg_sel;
    s_req(oag_pkg::MODE_REG) |-> s_res(oag_pkg::SPACE_REG)
      ##0 res.addr[2:0] == $past(req.opcode[2:0]);
  endproperty
  a_reg_sel: assert property (p_reg_sel) else $error("register select wrong");

  property p_direct;
    s_req(oag_pkg::MODE_DIRECT) |=> res.space ==
      ($past(req.byte2[7]) ? oag_pkg::SPACE_SFR : oag_pkg::SPACE_DATA);
  endproperty
  a_direct: assert property (p_direct) else $error("direct space wrong");

  property p_indirect;
    s_req(oag_pkg::MODE_INDIRECT) |=> res.space != oag_pkg::SPACE_SFR
      && res.addr[7:0] == $past(ptr);
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect reached SPECIAL_FUNCTION_REGISTER_SPACE");

  property p_imm8;
    s_req(oag_pkg::MODE_IMM8) |=> res.wr && res.wdata == $past(req.byte2);
  endproperty
  a_imm8: assert property (p_imm8) else $error("immediate byte wrong");

  property p_imm16;
    s_req(oag_pkg::MODE_IMM16) |=> res.data_pointer_16_load
      && res.data_pointer_16_val[15:8] == $past(req.byte2) && res.data_pointer_16_val[7:0] == $past(req.byte3);
  endproperty
  a_imm16: assert property (p_imm16) else $error("pointer load wrong");

  property p_ext_direct;
    s_req(oag_pkg::MODE_EXT_DIRECT) |-> s_res(oag_pkg::SPACE_EXT)
      ##0 res.addr == $past(req.data_pointer_16);
  endproperty
  a_ext_direct: assert property (p_ext_direct) else $error("external address wrong");

  property p_ext_ind;
    s_req(oag_pkg::MODE_EXT_INDIRECT) |=> res.illegal && res.space == oag_pkg::SPACE_NONE
      && !res.wr;
  endproperty
  a_ext_ind: assert property (p_ext_ind) else $error("external indirect accepted");

  property p_indexed;
    s_req(oag_pkg::MODE_INDEXED_DATA_POINTER_16) |=> res.space == oag_pkg::SPACE_CODE
      && res.addr == $past(req.data_pointer_16) + {8'h00, $past(req.acc)} && code_pending;
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  // Table read based on the program counter
  property p_indexed_pc;
    s_req(oag_pkg::MODE_INDEXED_PC) |=> res.space == oag_pkg::SPACE_CODE
      && res.addr == $past(req.pc_next) + {8'h00, $past(req.acc)} && code_pending;
  endproperty
  a_indexed_pc: assert property (p_indexed_pc) else $error("indexed from pc wrong");

  property p_acc_load;
    code_pending && code_rvalid |=> acc_load && acc_val == $past(code_rdata);
  endproperty
  a_acc_load: assert property (p_acc_load) else $error("code byte lost");

  // Answer with no new request ends the outstanding read
  property p_pending_clr;
    code_pending && code_rvalid && !req_valid |=> !code_pending;
  endproperty
  a_pending_clr: assert property (p_pending_clr) else $error("read still pending");

  property p_rel;
    s_req(oag_pkg::MODE_RELATIVE) |=> res.branch
      && res.addr == $past(req.pc_next) + {{8{$past(req.byte2[7])}}, $past(req.byte2)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");

  property p_page;
    s_req(oag_pkg::MODE_PAGE) |=> res.branch
      && res.addr[15:11] == $past(req.pc_next[15:11])
      && res.addr[10:8] == $past(req.opcode[7:5]) && res.addr[7:0] == $past(req.byte2);
  endproperty
  a_page: assert property (p_page) else $error("page target wrong");

  property p_long;
    s_req(oag_pkg::MODE_LONG) |=> res.addr == {$past(req.byte2), $past(req.byte3)};
  endproperty
  a_long: assert property (p_long) else $error("long target wrong");

  property p_bit_keep;
    s_req(oag_pkg::MODE_BIT) |=> (res.wdata ^ $past(req.cur_byte)) ==
      (($past(req.cur_byte[req.byte2[2:0]]) != $past(req.bit_val)) ?
       $past(bit_mask) : 8'h00);
  endproperty
  a_bit_keep: assert property (p_bit_keep) else $error("bit update disturbed");

  property p_bit_space;
    s_req(oag_pkg::MODE_BIT) |=> (res.space == oag_pkg::SPACE_DATA
      && res.addr[7:0] >= oag_pkg::BIT_RAM_BASE && res.addr[7:0] <= oag_pkg::BIT_RAM_LAST)
      || (res.space == oag_pkg::SPACE_SFR && res.addr[2:0] == 3'h0);
  endproperty
  a_bit_space: assert property (p_bit_space) else $error("bit byte out of range");

endmodule : oag_core
`default_nettype wire

// >>> common/oag_pkg.sv
// Shared types and constants of the operand address generator.
// Assumes a byte-wide core with a 16-bit program and data address space.
package oag_pkg;

  // Address widths
  localparam int ADDR_W = 16;
  localparam int PAGE_LOW_W = 11;

  // Working register select field of the opcode
  localparam int REG_SEL_LSB = 0;
  localparam int REG_SEL_W = 3;

  // Page branch opcode field holding target bits 10:8
  localparam int PAGE_OPC_MSB = 7;
  localparam int PAGE_OPC_LSB = 5;

  // Internal space boundaries
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] BIT_RAM_LAST = 8'h2F;
  localparam logic [2:0] BIT_SFR_LOW = 3'h0;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // Addressing mode requested by the instruction decoder
  typedef enum logic [3:0] {
    MODE_REG,
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_IMM8,
    MODE_IMM16,
    MODE_EXT_DIRECT,
    MODE_EXT_INDIRECT,
    MODE_INDEXED_PC,
    MODE_INDEXED_DATA_POINTER_16,
    MODE_RELATIVE,
    MODE_PAGE,
    MODE_LONG,
    MODE_BIT
  } oag_mode_e;

  // Address space reached by a result
  typedef enum logic [2:0] {
    SPACE_NONE,
    SPACE_REG,
    SPACE_DATA,
    SPACE_UPPER,
    SPACE_SFR,
    SPACE_EXT,
    SPACE_CODE,
    SPACE_PC
  } oag_space_e;

  // Request from the instruction decoder
  typedef struct packed {
    oag_mode_e mode;
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [7:0] acc;
    logic [15:0] pc_next;
    logic [15:0] data_pointer_16;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [7:0] cur_byte;
    logic bit_val;
    logic ext_write;
  } oag_req_s;

  // Generated address and data
  typedef struct packed {
    logic valid;
    oag_space_e space;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic data_pointer_16_load;
    logic [15:0] data_pointer_16_val;
    logic branch;
    logic illegal;
  } oag_res_s;

endpackage : oag_pkg

// >>> logic/oag_bit_map.sv
// Bit address mapper: bit address to byte address and masked update.
// Assumes the current byte value arrives with the bit address.
`timescale 1ns/1ps
`default_nettype none
module oag_bit_map (
  input wire logic [7:0] bit_addr, // Bit address from the instruction
  input wire logic [7:0] cur_byte, // Present value of the target byte
  input wire logic bit_val, // Value to set (1) or clear (0)
  output var oag_pkg::oag_space_e space, // Space holding the byte
  output logic [7:0] byte_addr, // Byte address of the bit
  output logic [7:0] mask, // One-hot mask of the bit
  output logic [7:0] new_byte // Byte with only that bit changed
);

  // Low half maps onto the bit field in data RAM, high half onto SFRs
  always_comb begin
    mask = 8'h01 << bit_addr[2:0];
    if (bit_addr[7] == 1'b0) begin
      space = oag_pkg::SPACE_DATA;
      byte_addr = oag_pkg::BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
    end else begin
      space = oag_pkg::SPACE_SFR;
      byte_addr = {bit_addr[7:3], oag_pkg::BIT_SFR_LOW};
    end
    // Other seven bits pass unchanged
    new_byte = bit_val ? (cur_byte | mask) : (cur_byte & ~mask);
  end

endmodule : oag_bit_map
`default_nettype wire

// >>> test/oag_code_mem.sv
// Program memory model that answers the code table reads of oag_core.
// Assumes the bench sets the answer latency; the data line toggles while idle.
`timescale 1ns/1ps
`default_nettype none
module oag_code_mem (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire oag_pkg::oag_res_s res, // Results of the generator
  input wire logic [3:0] lat, // Extra cycles before the answer
  output logic code_rvalid, // Read data strobe
  output logic [7:0] code_rdata // Read data
);
  logic [15:0] addr_q;
  logic [3:0] cnt;
  logic busy;

  // Take a code address, answer lat+1 cycles later, invert data when idle
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      code_rvalid <= 1'b0;
      code_rdata <= 8'h00;
      busy <= 1'b0;
      cnt <= 4'h0;
      addr_q <= 16'h0000;
    end else begin
      code_rvalid <= 1'b0;
      code_rdata <= ~code_rdata;
      if (busy && cnt == 4'h0) begin
        code_rvalid <= 1'b1;
        code_rdata <= addr_q[15:8] ^ addr_q[7:0] ^ 8'hA5;
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end else if (res.valid && res.space == oag_pkg::SPACE_CODE) begin
        addr_q <= res.addr;
        cnt <= lat;
        busy <= 1'b1;
      end
    end
  end
endmodule : oag_code_mem
`default_nettype wire

// >>> test/test_oag_core.sv
// Self-checking bench of oag_core with a program memory model.
// Assumes the result appears one cycle after each taken request.
`timescale 1ns/1ps
`default_nettype none
module test_oag_core;
  logic clk, rst, req_valid, code_rvalid, code_pending, acc_load;
  logic [7:0] code_rdata, acc_val;
  logic [3:0] lat;
  oag_pkg::oag_req_s req;
  oag_pkg::oag_res_s res;
  int error_cnt, samples_checked;

  oag_core i_oag_core (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .code_rvalid(code_rvalid), .code_rdata(code_rdata), .res(res),
    .code_pending(code_pending), .acc_load(acc_load), .acc_val(acc_val));
  oag_code_mem i_oag_code_mem (.clk(clk), .rst(rst), .res(res), .lat(lat),
    .code_rvalid(code_rvalid), .code_rdata(code_rdata));

  // Compare of plain values
  task chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  // Compare of address spaces
  task chk_space(input oag_pkg::oag_space_e exp, input oag_pkg::oag_space_e got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected space expected %s seen %s", exp.name(), got.name());
    end
  endtask : chk_space

  // One request pulse, then look at the one-cycle result
  task go;
    @(negedge clk) req_valid = 1'b1;
    @(negedge clk) req_valid = 1'b0;
    chk_val("valid", 16'h0001, {15'h0, res.valid});
  endtask : go

  task t_reg;
    for (int r = 0; r < 8; r++) begin
      req.mode = oag_pkg::MODE_REG;
      req.opcode = 8'hE8 | 8'(r);
      go();
      chk_val("reg addr", 16'(r), res.addr);
      chk_space(oag_pkg::SPACE_REG, res.space);
    end
  endtask : t_reg

  // Direct and indirect across the 7Fh/80h boundary
  task t_internal;
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      b = 8'h7F + 8'(i);
      req.mode = oag_pkg::MODE_DIRECT;
      req.byte2 = b;
      go();
      chk_val("direct addr", {8'h00, b}, res.addr);
      chk_space(b[7] ? oag_pkg::SPACE_SFR : oag_pkg::SPACE_DATA, res.space);
      req.mode = oag_pkg::MODE_INDIRECT;
      req.opcode = {7'h73, i[0]};
      req.ptr0 = i[0] ? 8'h11 : b;
      req.ptr1 = i[0] ? b : 8'h22;
      go();
      chk_val("indirect addr", {8'h00, b}, res.addr);
      chk_space(b[7] ? oag_pkg::SPACE_UPPER : oag_pkg::SPACE_DATA, res.space);
    end
  endtask : t_internal

  task t_imm;
    req.mode = oag_pkg::MODE_IMM8;
    req.opcode = 8'h7D;
    req.byte2 = 8'hA5;
    go();
    chk_val("imm addr", 16'h0005, res.addr);
    chk_val("imm data", 16'h00A5, {8'h00, res.wdata});
    chk_val("imm wr", 16'h0001, {15'h0, res.wr});
    req.mode = oag_pkg::MODE_IMM16;
    req.byte2 = 8'h12;
    req.byte3 = 8'h34;
    go();
    chk_val("data_pointer_16 load", 16'h0001, {15'h0, res.data_pointer_16_load});
    chk_val("data_pointer_16 val", 16'h1234, res.data_pointer_16_val);
  endtask : t_imm

  // External direct read and write, then the refused indirect form
  task t_ext;
    for (int i = 0; i < 2; i++) begin
      req.mode = oag_pkg::MODE_EXT_DIRECT;
      req.data_pointer_16 = 16'hBEEF;
      req.acc = 8'h3C;
      req.ext_write = i[0];
      go();
      chk_space(oag_pkg::SPACE_EXT, res.space);
      chk_val("ext addr", 16'hBEEF, res.addr);
      chk_val("ext wr", 16'(i), {15'h0, res.wr});
      chk_val("ext data", 16'h003C, {8'h00, res.wdata});
    end
    req.mode = oag_pkg::MODE_EXT_INDIRECT;
    go();
    chk_val("illegal", 16'h0001, {15'h0, res.illegal});
    chk_val("illegal wr", 16'h0000, {15'h0, res.wr});
    chk_space(oag_pkg::SPACE_NONE, res.space);
    req.mode = oag_pkg::oag_mode_e'(4'hF);
    go();
    chk_val("unknown mode", 16'h0001, {15'h0, res.illegal});
    chk_space(oag_pkg::SPACE_NONE, res.space);
  endtask : t_ext

  task t_index(input oag_pkg::oag_mode_e m, input logic [15:0] base, input logic [7:0] a,
               input logic [3:0] l);
    logic [15:0] e;
    e = base + {8'h00, a};
    lat = l;
    req.mode = m;
    req.acc = a;
    req.pc_next = (m == oag_pkg::MODE_INDEXED_PC) ? base : ~base;
    req.data_pointer_16 = (m == oag_pkg::MODE_INDEXED_PC) ? ~base : base;
    go();
    chk_val("code addr", e, res.addr);
    chk_space(oag_pkg::SPACE_CODE, res.space);
    chk_val("pending", 16'h0001, {15'h0, code_pending});
    for (int n = 0; n < 20 && acc_load !== 1'b1; n++) @(negedge clk);
    chk_val("acc load", 16'h0001, {15'h0, acc_load});
    chk_val("acc val", {8'h00, e[15:8] ^ e[7:0] ^ 8'hA5}, {8'h00, acc_val});
    chk_val("pending", 16'h0000, {15'h0, code_pending});
  endtask : t_index

  task t_branch(input oag_pkg::oag_mode_e m, input logic [7:0] opc, input logic [15:0] pc,
                input logic [7:0] b2, input logic [7:0] b3, input logic [15:0] e);
    req.mode = m;
    req.opcode = opc;
    req.pc_next = pc;
    req.byte2 = b2;
    req.byte3 = b3;
    go();
    chk_val("target", e, res.addr);
    chk_val("branch", 16'h0001, {15'h0, res.branch});
    chk_space(oag_pkg::SPACE_PC, res.space);
  endtask : t_branch

  task t_bit(input logic [7:0] b, input logic [7:0] cur, input logic v);
    logic [7:0] m;
    m = 8'h01 << b[2:0];
    req.mode = oag_pkg::MODE_BIT;
    req.byte2 = b;
    req.cur_byte = cur;
    req.bit_val = v;
    go();
    chk_space(b[7] ? oag_pkg::SPACE_SFR : oag_pkg::SPACE_DATA, res.space);
    chk_val("bit addr", b[7] ? {8'h00, b[7:3], 3'h0} : 16'h0020 + 16'(b[6:3]), res.addr);
    chk_val("bit data", {8'h00, v ? (cur | m) : (cur & ~m)}, {8'h00, res.wdata});
    chk_val("bit wr", 16'h0001, {15'h0, res.wr});
  endtask : t_bit

  // Reset in mid-run clears address, space, write, branch and pending flags and accumulator outputs
  task t_reset;
    @(negedge clk) rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk_val("rst addr", 16'h0000, res.addr);
    chk_val("rst acc", 16'h0000, {8'h00, acc_val});
    chk_val("rst flags", 16'h0000, {12'h000, res.wr, res.branch, acc_load, code_pending});
    chk_space(oag_pkg::SPACE_NONE, res.space);
  endtask : t_reset

  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Clock of 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far above the expected run
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lat = 4'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk_val("idle valid", 16'h0000, {15'h0, res.valid});
    chk_space(oag_pkg::SPACE_NONE, res.space);
    t_reg();
    t_internal();
    t_imm();
    t_ext();
    t_index(oag_pkg::MODE_INDEXED_PC, 16'hFFFE, 8'h05, 4'h0);
    t_index(oag_pkg::MODE_INDEXED_DATA_POINTER_16, 16'h1000, 8'hFF, 4'h3);
    t_branch(oag_pkg::MODE_RELATIVE, 8'h80, 16'h1002, 8'h32, 8'h00, 16'h1034);
    t_branch(oag_pkg::MODE_RELATIVE, 8'h80, 16'h1002, 8'h80, 8'h00, 16'h0F82);
    t_branch(oag_pkg::MODE_PAGE, 8'hA1, 16'h4002, 8'h00, 8'h00, 16'h4500);
    t_branch(oag_pkg::MODE_PAGE, 8'hE1, 16'hFFFF, 8'hFF, 8'h00, 16'hFFFF);
    t_branch(oag_pkg::MODE_LONG, 8'h02, 16'h0000, 8'h12, 8'h34, 16'h1234);
    t_bit(8'h00, 8'hF0, 1'b1);
    t_bit(8'h7F, 8'hFF, 1'b0);
    t_bit(8'hAB, 8'h00, 1'b1);
    t_bit(8'hF8, 8'hFF, 1'b0);
    t_reset();
    t_branch(oag_pkg::MODE_LONG, 8'h02, 16'h0000, 8'hAB, 8'hCD, 16'hABCD);
    end_of_test();
  end
endmodule : test_oag_core
`default_nettype wire
